// File: rtl/servo_mode_defines.vh
// Constants for the servo control-selection logic.
// Assumes a single 10 MHz core clock and digitised analog inputs.
`ifndef SERVO_MODE_DEFINES_VH
`define SERVO_MODE_DEFINES_VH

// ----------------------------------------------------------------
// Control mode setting codes
// ----------------------------------------------------------------
`define MODE_SPEED        4'h0
`define MODE_TORQUE       4'h2
`define MODE_CHANGE       4'h3

// ----------------------------------------------------------------
// Offset range in millivolts
// ----------------------------------------------------------------
`define OFFSET_MAX_MV     999
`define OFFSET_MIN_MV     (-999)

// ----------------------------------------------------------------
// Drive direction codes
// ----------------------------------------------------------------
`define DIR_STOP          2'h0
`define DIR_CCW           2'h1
`define DIR_CW            2'h2

// ----------------------------------------------------------------
// Display selection codes
// ----------------------------------------------------------------
`define DISP_SPEED        2'h0
`define DISP_TORQUE       2'h1
`define DISP_DATA         2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ            10000000
`define SPLASH_MS         2000
`define SPLASH_CYCLES     ((`CLK_HZ / 1000) * `SPLASH_MS)
`define FILTER_US         3555
`define FILTER_CYCLES     ((`CLK_HZ / 1000000) * `FILTER_US)

`endif

// File: rtl/contact_filter.v
// Input filter for one contact: two-flop synchroniser, then a
// stability counter. Assumes the contact is asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module contact_filter #(
   parameter integer CNT_W  = 16,
   parameter integer CYCLES = 35550
) (
   input  wire core_clk,
   input  wire sys_rst,
   input  wire raw,
   output reg  clean
);

   // ----------------------------------------------------------------
   // Synchroniser
   // ----------------------------------------------------------------
   reg             meta_q;
   reg             sync_q;
   reg [CNT_W-1:0] cnt_q;

   always @(posedge core_clk) begin
      if (sys_rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= raw;
         sync_q <= meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Stability filter
   // ----------------------------------------------------------------
   // Chatter shorter than the filter window never reaches the decoders
   always @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_q <= {CNT_W{1'b0}};
         clean <= 1'b0;
      end else if (sync_q == clean) begin
         cnt_q <= {CNT_W{1'b0}};
      end else if (cnt_q >= CYCLES[CNT_W-1:0] - 1'b1) begin
         cnt_q <= {CNT_W{1'b0}};
         clean <= sync_q;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

endmodule

`default_nettype wire

// File: rtl/servo_speed_limit_mode_select.v
// Control-selection logic: mode choice, speed/torque limit sources,
// drive direction, limit-reached flag and power-on display sequence.
// Assumes analog inputs arrive already digitised on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "servo_mode_defines.vh"

module servo_speed_limit_mode_select #(
   parameter integer W          = 16,
   parameter integer FILT_CYC   = `FILTER_CYCLES,
   parameter integer SPLASH_CYC = `SPLASH_CYCLES
) (
   input  wire                core_clk,
   input  wire                sys_rst,
   input  wire [3:0]          mode_setting,
   input  wire signed [W-1:0] analog_torque_cmd,
   input  wire signed [W-1:0] torque_offset_mv,
   input  wire [W-1:0]        analog_torque_limit,
   input  wire [W-1:0]        torque_limit1,
   input  wire signed [W-1:0] analog_speed_limit,
   input  wire [7*W-1:0]      internal_speed_limits,
   input  wire [W-1:0]        speed_cmd,
   input  wire signed [W-1:0] motor_speed,
   input  wire                fwd_dir_select,
   input  wire                rev_dir_select,
   input  wire                speed_sel_bit1,
   input  wire                speed_sel_bit2,
   input  wire                speed_sel_bit3,
   input  wire                control_change_input,
   input  wire                fwd_start_input,
   input  wire                rev_start_input,
   input  wire                servo_enable_input,
   output reg                 torque_mode,
   output reg  [1:0]          drive_dir,
   output reg                 coast,
   output reg                 decel_stop,
   output reg                 servo_locked,
   output reg  signed [W-1:0] torque_cmd_out,
   output reg  [W-1:0]        torque_limit_out,
   output reg  [W-1:0]        speed_limit_out,
   output reg                 limiting_speed_flag,
   output reg  [1:0]          display_sel
);

   // ----------------------------------------------------------------
   // Contact filtering
   // ----------------------------------------------------------------
   localparam integer NIN = 9;
   wire [NIN-1:0] raw_in;
   wire [NIN-1:0] filt;

   assign raw_in = {servo_enable_input, rev_start_input, fwd_start_input,
                    control_change_input, speed_sel_bit3, speed_sel_bit2,
                    speed_sel_bit1, rev_dir_select, fwd_dir_select};

   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi = gi + 1) begin : g_filt
         contact_filter #(
            .CNT_W  (16),
            .CYCLES (FILT_CYC)
         ) u_filt (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .raw      (raw_in[gi]),
            .clean    (filt[gi])
         );
      end
   endgenerate

   wire       f_fwd_sel = filt[0];
   wire       f_rev_sel = filt[1];
   wire [2:0] f_sp      = filt[4:2];
   wire       f_chg     = filt[5];
   wire       f_st1     = filt[6];
   wire       f_st2     = filt[7];
   wire       f_son     = filt[8];

   // ----------------------------------------------------------------
   // Mode latch
   // ----------------------------------------------------------------
   // Sampled once after reset release; later writes wait for a power cycle
   reg       mode_valid_q;
   reg [3:0] mode_q;

   always @(posedge core_clk) begin
      if (sys_rst) begin
         mode_valid_q <= 1'b0;
         mode_q       <= `MODE_SPEED;
      end else if (!mode_valid_q) begin
         mode_valid_q <= 1'b1;
         mode_q       <= mode_setting;
      end
   end

   reg torque_now;
   always @* begin
      case (mode_q)
         `MODE_TORQUE: torque_now = 1'b1;
         `MODE_CHANGE: torque_now = f_chg;
         default:      torque_now = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Limit selection and command shaping
   // ----------------------------------------------------------------
   // Offset bounds held at sum width so the clamp never truncates
   localparam signed [W+1:0] OFF_MAX = `OFFSET_MAX_MV;
   localparam signed [W+1:0] OFF_MIN = `OFFSET_MIN_MV;
   reg        [W-1:0] int_lim;
   reg        [W-1:0] sel_lim;
   reg signed [W+1:0] off_clamp;
   reg signed [W+1:0] tc_sum;
   reg signed [W-1:0] tc_d;
   reg        [W-1:0] abs_spd;
   reg                at_limit;

   always @* begin
      int_lim = internal_speed_limits[W-1:0];
      if (f_sp != 3'h0)
         int_lim = internal_speed_limits[(f_sp-3'h1)*W +: W];
      sel_lim = (f_sp == 3'h0) ?
                (analog_speed_limit[W-1] ? -analog_speed_limit
                                         : analog_speed_limit)
                : int_lim;
      off_clamp = {{2{torque_offset_mv[W-1]}}, torque_offset_mv};
      if (off_clamp > OFF_MAX)
         off_clamp = OFF_MAX;
      if (off_clamp < OFF_MIN)
         off_clamp = OFF_MIN;
      tc_sum = analog_torque_cmd + off_clamp;
      // Saturate so an offset cannot wrap a full-scale command
      if (tc_sum > $signed({3'b000, {(W-1){1'b1}}}))
         tc_d = {1'b0, {(W-1){1'b1}}};
      else if (tc_sum < $signed({3'b111, {(W-1){1'b0}}}))
         tc_d = {1'b1, {(W-1){1'b0}}};
      else
         tc_d = tc_sum[W-1:0];
      abs_spd  = motor_speed[W-1] ? -motor_speed : motor_speed;
      at_limit = abs_spd >= sel_lim;
   end

   // ----------------------------------------------------------------
   // Direction decode
   // ----------------------------------------------------------------
   reg [1:0] dir_d;
   reg       coast_d;
   reg       decel_d;
   reg       lim_neg;

   always @* begin
      dir_d   = `DIR_STOP;
      coast_d = 1'b0;
      decel_d = 1'b0;
      lim_neg = (f_sp == 3'h0) && analog_speed_limit[W-1];
      if (!f_son) begin
         coast_d = 1'b1;
      end else if (torque_now) begin
         if (f_fwd_sel == f_rev_sel)
            coast_d = 1'b1;
         else if (f_fwd_sel)
            dir_d = lim_neg ? `DIR_CW : `DIR_CCW;
         else
            dir_d = lim_neg ? `DIR_CCW : `DIR_CW;
      end else begin
         if (f_st1 && !f_st2)
            dir_d = `DIR_CCW;
         else if (f_st2 && !f_st1)
            dir_d = `DIR_CW;
         else
            decel_d = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (sys_rst) begin
         torque_mode         <= 1'b0;
         drive_dir           <= `DIR_STOP;
         coast               <= 1'b1;
         decel_stop          <= 1'b0;
         servo_locked        <= 1'b0;
         torque_cmd_out      <= {W{1'b0}};
         torque_limit_out    <= {W{1'b0}};
         speed_limit_out     <= {W{1'b0}};
         limiting_speed_flag <= 1'b0;
      end else begin
         torque_mode      <= torque_now;
         drive_dir        <= dir_d;
         coast            <= coast_d;
         decel_stop       <= decel_d;
         servo_locked     <= f_son && !coast_d;
         torque_cmd_out   <= torque_now ? tc_d : {W{1'b0}};
         // Analog torque limit is deliberately unused in torque mode
         torque_limit_out <= torque_now ? torque_limit1
                             : ((analog_torque_limit < torque_limit1) ?
                                analog_torque_limit : torque_limit1);
         speed_limit_out  <= torque_now ? sel_lim : speed_cmd;
         limiting_speed_flag <= torque_now && f_son && at_limit;
      end
   end

   // ----------------------------------------------------------------
   // Power-on display
   // ----------------------------------------------------------------
   reg [31:0] splash_q;

   always @(posedge core_clk) begin
      if (sys_rst) begin
         splash_q    <= 32'h0;
         display_sel <= `DISP_SPEED;
      end else if (splash_q < SPLASH_CYC) begin
         splash_q    <= splash_q + 32'h1;
         display_sel <= (mode_q == `MODE_TORQUE) ? `DISP_TORQUE
                                                 : `DISP_SPEED;
      end else begin
         display_sel <= `DISP_DATA;
      end
   end

endmodule

`default_nettype wire

// File: dv/servo_sel_assertions.sv
// Checker for the servo control-selection block, ports only.
// Assumes one core_clk domain and sys_rst synchronous active high.
`timescale 1ns/1ps
`default_nettype none
module servo_sel_assertions #(
   parameter integer W          = 16,
   parameter integer SPLASH_CYC = 10
) (
   input wire logic                core_clk,
   input wire logic                sys_rst,
   input wire logic signed [W-1:0] analog_torque_cmd,
   input wire logic signed [W-1:0] torque_offset_mv,
   input wire logic [W-1:0]        torque_limit1,
   input wire logic [W-1:0]        speed_cmd,
   input wire logic                torque_mode,
   input wire logic [1:0]          drive_dir,
   input wire logic                coast,
   input wire logic                servo_locked,
   input wire logic signed [W-1:0] torque_cmd_out,
   input wire logic [W-1:0]        torque_limit_out,
   input wire logic [W-1:0]        speed_limit_out,
   input wire logic                limiting_speed_flag,
   input wire logic [1:0]          display_sel
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ------------------------------------------------------------
   // Cycles since reset release, saturating so it never wraps
   // ------------------------------------------------------------
   logic [7:0] up_q;
   always @(posedge core_clk) begin
      if (sys_rst)
         up_q <= 8'h00;
      else if (up_q != 8'hff)
         up_q <= up_q + 8'h01;
   end
   sequence s_torque2;
      torque_mode ##1 torque_mode;
   endsequence
   sequence s_speed3;
      (!torque_mode) [*3];
   endsequence
   // Small operands only, so saturation cannot mask the sum
   property p_offset_add;
      s_torque2 ##0 ($past(torque_offset_mv) <= 999 &&
         $past(torque_offset_mv) >= -999 &&
         $past(analog_torque_cmd) <= 1000 &&
         $past(analog_torque_cmd) >= -1000)
      |-> torque_cmd_out ==
         $past(analog_torque_cmd) + $past(torque_offset_mv);
   endproperty
   property p_limit_one;
      s_torque2 |-> torque_limit_out == $past(torque_limit1);
   endproperty
   property p_speed_pass;
      s_speed3 |-> speed_limit_out == $past(speed_cmd);
   endproperty
   property p_coast_stop;
      coast |-> drive_dir == 2'h0;
   endproperty
   property p_lock;
      servo_locked |-> !coast;
   endproperty
   property p_flag_torque;
      limiting_speed_flag |-> torque_mode;
   endproperty
   property p_splash;
      (up_q < SPLASH_CYC - 1) |-> display_sel != 2'h2;
   endproperty
   property p_data;
      (up_q > SPLASH_CYC + 2) |-> display_sel == 2'h2;
   endproperty
   a_offset_add: assert property (p_offset_add)
      else $error("torque command offset sum wrong");
   a_limit_one: assert property (p_limit_one)
      else $error("torque limit not internal limit one");
   a_speed_pass: assert property (p_speed_pass)
      else $error("speed setting not passed in speed mode");
   a_coast_stop: assert property (p_coast_stop)
      else $error("drive direction set while coasting");
   a_lock: assert property (p_lock)
      else $error("locked while coasting");
   a_flag_torque: assert property (p_flag_torque)
      else $error("limiting flag outside torque mode");
   a_splash: assert property (p_splash)
      else $error("data shown before splash ended");
   a_data: assert property (p_data)
      else $error("data not shown after splash");
endmodule
`default_nettype wire

// File: dv/host_contacts.sv
// Host controller model driving the contact inputs.
// Assumes the bench hands the wanted contact levels on want.
`timescale 1ns/1ps
`default_nettype none
module host_contacts (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic [8:0] want,
   output var  logic [8:0] pins
);
   initial pins = 9'h000;
   // Servo enable held off while power is coming up
   always @(negedge core_clk) begin
      pins <= sys_rst ? {1'b0, want[7:0]} : want;
   end
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the servo control-selection block.
// Assumes short filter and splash counts set at the instance.
`timescale 1ns/1ps
`default_nettype none
`include "servo_mode_defines.vh"
module tb;
   localparam integer W = 16;
   logic                core_clk, sys_rst;
   logic [3:0]          mode_setting = 4'h0;
   logic signed [W-1:0] analog_torque_cmd = 16'sh03e8;
   logic signed [W-1:0] torque_offset_mv = 16'sh012c;
   logic signed [W-1:0] analog_speed_limit = 16'sh0258;
   logic signed [W-1:0] motor_speed = 16'sh0000;
   logic [W-1:0]        analog_torque_limit = 16'h0100;
   logic [W-1:0]        torque_limit1 = 16'h0200;
   logic [W-1:0]        speed_cmd = 16'h0123;
   logic [7*W-1:0]      internal_speed_limits;
   logic [8:0]          want = 9'h000;
   wire  [8:0]          pins;
   wire                 torque_mode, coast, decel_stop, servo_locked;
   wire                 limiting_speed_flag;
   wire  [1:0]          drive_dir, display_sel;
   wire  [W-1:0]        torque_cmd_out, torque_limit_out, speed_limit_out;
   integer              n_errors = 0;
   integer              n_compared = 0;
   host_contacts i_host_contacts (.core_clk, .sys_rst, .want, .pins);
   servo_speed_limit_mode_select #(.W(W), .FILT_CYC(4), .SPLASH_CYC(10))
   i_servo_speed_limit_mode_select (.core_clk, .sys_rst, .mode_setting,
      .analog_torque_cmd, .torque_offset_mv, .analog_torque_limit,
      .torque_limit1, .analog_speed_limit, .internal_speed_limits,
      .speed_cmd, .motor_speed, .fwd_dir_select(pins[7]),
      .rev_dir_select(pins[6]), .speed_sel_bit1(pins[3]),
      .speed_sel_bit2(pins[4]), .speed_sel_bit3(pins[5]),
      .control_change_input(pins[2]), .fwd_start_input(pins[1]),
      .rev_start_input(pins[0]), .servo_enable_input(pins[8]),
      .torque_mode, .drive_dir, .coast, .decel_stop, .servo_locked,
      .torque_cmd_out, .torque_limit_out, .speed_limit_out,
      .limiting_speed_flag, .display_sel);
   // ------------------------------------------------------------
   // Clock, tasks
   // ------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input integer n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic power_up(input logic [3:0] m);
      sys_rst = 1'b1;
      mode_setting = m;
      cyc(5);
      sys_rst = 1'b0;
   endtask
   // Long wait covers synchroniser plus filter plus output stage
   task automatic set_in(input logic s, f, r, input logic [2:0] c,
                         input logic l, a, b);
      want = {s, f, r, c, l, a, b};
      cyc(14);
   endtask
   task automatic print_verdict;
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      integer k;
      for (k = 1; k <= 7; k++) begin
         internal_speed_limits[(k-1)*W +: W] = W'(k * 256);
      end
      power_up(4'h0);
      cyc(3);
      check(display_sel, `DISP_SPEED);
      set_in(1, 0, 0, 3'h0, 0, 1, 0);
      check(display_sel, `DISP_DATA);
      check(drive_dir, `DIR_CCW);
      check(speed_limit_out, 16'h0123);
      check(torque_limit_out, 16'h0100);
      check(torque_cmd_out, 16'h0000);
      check(servo_locked, 1'b1);
      mode_setting = 4'h2;
      cyc(3);
      check(torque_mode, 1'b0);
      set_in(1, 0, 0, 3'h0, 0, 0, 1);
      check(drive_dir, `DIR_CW);
      set_in(1, 0, 0, 3'h0, 0, 1, 1);
      check(decel_stop, 1'b1);
      power_up(4'h2);
      cyc(3);
      check(display_sel, `DISP_TORQUE);
      set_in(1, 1, 0, 3'h0, 0, 0, 0);
      check(torque_mode, 1'b1);
      check(torque_cmd_out, 16'h0514);
      check(torque_limit_out, 16'h0200);
      check(drive_dir, `DIR_CCW);
      check(coast, 1'b0);
      check(speed_limit_out, 16'h0258);
      motor_speed = 16'sh0258;
      cyc(3);
      check(limiting_speed_flag, 1'b1);
      torque_offset_mv = 16'shfa24;
      analog_speed_limit = 16'shfda8;
      motor_speed = 16'sh0064;
      cyc(3);
      check(torque_cmd_out, 16'h0001);
      check(drive_dir, `DIR_CW);
      check(limiting_speed_flag, 1'b0);
      set_in(1, 0, 1, 3'h0, 0, 0, 0);
      check(drive_dir, `DIR_CCW);
      for (k = 1; k <= 7; k++) begin
         set_in(1, 1, 0, k[2:0], 0, 0, 0);
         check(speed_limit_out, W'(k * 256));
         check(drive_dir, `DIR_CCW);
      end
      set_in(1, 0, 1, 3'h7, 0, 0, 0);
      check(drive_dir, `DIR_CW);
      for (k = 0; k <= 1; k++) begin
         set_in(1, k[0], k[0], 3'h0, 0, 0, 0);
         check(coast, 1'b1);
         check(drive_dir, `DIR_STOP);
      end
      power_up(4'h3);
      set_in(1, 1, 0, 3'h0, 0, 1, 0);
      check(torque_mode, 1'b0);
      set_in(1, 1, 0, 3'h0, 1, 1, 0);
      check(torque_mode, 1'b1);
      set_in(1, 1, 0, 3'h0, 0, 0, 0);
      check(torque_mode, 1'b0);
      check(decel_stop, 1'b1);
      print_verdict();
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      n_errors++;
      print_verdict();
   end
endmodule
bind servo_speed_limit_mode_select servo_sel_assertions #(.W(W),
   .SPLASH_CYC(SPLASH_CYC)) i_servo_sel_assertions (.core_clk, .sys_rst,
   .analog_torque_cmd, .torque_offset_mv, .torque_limit1, .speed_cmd,
   .torque_mode, .drive_dir, .coast, .servo_locked, .torque_cmd_out,
   .torque_limit_out, .speed_limit_out, .limiting_speed_flag, .display_sel);
`default_nettype wire
